// ==== verilog/sgc_global_ctrl.sv ====
// Global control bits of the switch: register bank and their effects.
// Assumes a classic Wishbone master; frame and table ports come from the engine.
module sgc_global_ctrl
  import sgc_pkg::*;
#(
  parameter longint NORM_CYC = NORM_AGE_CYC,
  parameter int     FAST_CYC = FAST_AGE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Strap and port status
  input  wire logic        pause_dis_strap,
  input  wire logic [3:0]  link_up,
  input  wire logic [3:0]  learn_dis,
  input  wire logic [3:0]  an_tx_pause,
  input  wire logic [3:0]  an_rx_pause,
  // Frame classification
  input  wire sgc_frame_s  frame_in,
  output logic             frame_drop,
  // Static table walk
  input  wire sgc_entry_s  table_entry,
  output logic [9:0]       table_index,
  output logic             table_clear,
  // Aging
  output logic             age_tick,
  output logic             age_all,
  // Control outputs
  output logic             large_frame_enable,
  output logic [3:0]       tx_flow_en,
  output logic [3:0]       rx_flow_en,
  output logic             aggressive_backoff,
  output logic             flush_busy
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [4:0]  gc0;
    logic [7:0]  gc1;
    logic        strap_done;
    sgc_flush_e  fstate;
    logic [9:0]  idx;
    logic        clr;
    logic        fast_pass;
    logic        pass_q;
    logic [3:0]  link_q;
    logic        age_all;
    logic        drop;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } sgc_ctrl_s;

  sgc_ctrl_s st;
  sgc_ctrl_s next_st;
  logic      tick;
  logic [3:0] link_lost;

  function automatic logic one_hot4(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic sel);
    return sel ? d[7:0] : old;
  endfunction

  assign link_lost = st.link_q & ~link_up;

  // ==========================================================================
  // Aging timer
  sgc_age_timer #(
    .NORM_CYC (NORM_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .age_en   (st.gc1[GC1_AGE_BIT]),
    .fast     (st.gc1[GC1_FAST_BIT] | st.fast_pass),
    .age_tick (tick)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic [7:0] b;
    logic       hit;
    b = 8'h00;
    hit = 1'b0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.clr = 1'b0;
    next_st.age_all = 1'b0;
    next_st.link_q = link_up;
    next_st.pass_q = st.fast_pass;

    // Strap sampled once after reset release
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.gc1[GC1_TXPD_BIT] = pause_dis_strap;
      next_st.gc1[GC1_RXPD_BIT] = pause_dis_strap;
    end

    // Link-loss fast pass
    if (link_lost != 4'h0) begin
      next_st.age_all = 1'b1;
      if (st.gc0[GC0_LINKAGE_BIT]) begin
        next_st.fast_pass = 1'b1;
      end
    end else if (tick && st.fast_pass && st.pass_q) begin
      // A tick launched before the pass began must not end it
      next_st.fast_pass = 1'b0;
    end

    // Static table flush walk
    case (st.fstate)
      SGC_IDLE: begin
        next_st.idx = '0;
      end
      SGC_FLUSH: begin
        hit = table_entry.valid && one_hot4(table_entry.ports) && !table_entry.multicast
              && ((table_entry.ports & learn_dis) != 4'h0);
        next_st.clr = hit;
        next_st.idx = st.idx + 10'h1;
        if (st.idx == 10'(FLUSH_ENTRIES - 1)) begin
          next_st.fstate = SGC_IDLE;
          next_st.gc0[GC0_FLUSH_BIT] = 1'b0;
        end
      end
      default: begin
        next_st.fstate = SGC_IDLE;
      end
    endcase

    // Frame filter
    next_st.drop = 1'b0;
    if (frame_in.valid) begin
      if (st.gc0[GC0_PFILT_BIT]) begin
        if (frame_in.len_type == PAUSE_ETHERTYPE || frame_in.da == PAUSE_DA) begin
          next_st.drop = 1'b1;
        end
      end else if (frame_in.is_pause) begin
        next_st.drop = 1'b1;
      end
      if (st.gc1[GC1_LENCHK_BIT] && frame_in.len_type < LEN_LIMIT
          && frame_in.len_type != {4'h0, frame_in.length}) begin
        next_st.drop = 1'b1;
      end
      if (frame_in.length > (st.gc1[GC1_LARGE_BIT] ? LARGE_FRAME_MAX : STD_FRAME_MAX)) begin
        next_st.drop = 1'b1;
      end
    end

    // Wishbone slave, one wait state
    if (wb_cyc_i && wb_stb_i && !st.ack && !st.err) begin
      if (wb_adr_i == REG_GC0_ADDR) begin
        next_st.ack = 1'b1;
        next_st.rdata = {24'h0, 3'h0, st.gc0};
        if (wb_we_i && wb_sel_i[0]) begin
          b = wr_byte({3'h0, st.gc0}, wb_dat_i, wb_sel_i[0]);
          next_st.gc0[GC0_PFILT_BIT] = b[GC0_PFILT_BIT];
          next_st.gc0[GC0_LINKAGE_BIT] = b[GC0_LINKAGE_BIT];
          if (b[GC0_FLUSH_BIT] && st.fstate == SGC_IDLE) begin
            next_st.gc0[GC0_FLUSH_BIT] = 1'b1;
            next_st.fstate = SGC_FLUSH;
          end
        end
      end else if (wb_adr_i == REG_GC1_ADDR) begin
        next_st.ack = 1'b1;
        next_st.rdata = {24'h0, st.gc1};
        if (wb_we_i && wb_sel_i[0]) begin
          b = wr_byte(st.gc1, wb_dat_i, wb_sel_i[0]);
          next_st.gc1 = {1'b0, b[6:0]};
        end
      end else if (wb_adr_i == REG_STAT_ADDR) begin
        next_st.ack = 1'b1;
        next_st.rdata = {22'h0, st.fast_pass, st.fstate == SGC_FLUSH, link_up, learn_dis};
      end else begin
        next_st.err = 1'b1;
        next_st.rdata = 32'h0;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.gc0 <= GC0_RESET;
      st.gc1 <= GC1_RESET;
      st.fstate <= SGC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign wb_err_o = st.err;
  assign frame_drop = st.drop;
  assign table_index = st.idx;
  assign table_clear = st.clr;
  assign age_tick = tick;
  assign age_all = st.age_all;
  assign large_frame_enable = st.gc1[GC1_LARGE_BIT];
  assign tx_flow_en = st.gc1[GC1_TXPD_BIT] ? 4'h0 : an_tx_pause;
  assign rx_flow_en = st.gc1[GC1_RXPD_BIT] ? 4'h0 : an_rx_pause;
  assign aggressive_backoff = st.gc1[GC1_BACKOFF_BIT];
  assign flush_busy = st.fstate == SGC_FLUSH;

endmodule

// ==== verilog/sgc_pkg.sv ====
// Package for the switch global control bank: register map, fields, timing.
// Assumes a 100 MHz core clock and a classic Wishbone register bus.
package sgc_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0] REG_GC0_ADDR = 8'h08;
  localparam logic [7:0] REG_GC1_ADDR = 8'h0c;
  localparam logic [7:0] REG_STAT_ADDR = 8'h10;

  // ==========================================================================
  // Control register 0, low bits
  localparam int GC0_FLUSH_BIT = 4;
  localparam int GC0_RSV3_BIT = 3;
  localparam int GC0_RSV2_BIT = 2;
  localparam int GC0_PFILT_BIT = 1;
  localparam int GC0_LINKAGE_BIT = 0;
  localparam logic [4:0] GC0_RESET = 5'h0c;

  // ==========================================================================
  // Control register 1
  localparam int GC1_LARGE_BIT = 6;
  localparam int GC1_TXPD_BIT = 5;
  localparam int GC1_RXPD_BIT = 4;
  localparam int GC1_LENCHK_BIT = 3;
  localparam int GC1_AGE_BIT = 2;
  localparam int GC1_FAST_BIT = 1;
  localparam int GC1_BACKOFF_BIT = 0;
  localparam logic [7:0] GC1_RESET = 8'h04;

  // ==========================================================================
  // Frame constants
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
  localparam logic [15:0] LEN_LIMIT = 16'h05dc;
  localparam logic [11:0] LARGE_FRAME_MAX = 12'h800;
  localparam logic [11:0] STD_FRAME_MAX = 12'h600;
  localparam int NUM_PORTS = 4;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int FAST_AGE_US = 800;
  localparam int NORM_AGE_S = 300;
  localparam int FAST_AGE_CYC = FAST_AGE_US * CLK_MHZ;
  localparam longint NORM_AGE_CYC = longint'(NORM_AGE_S) * 1000000 * CLK_MHZ;
  localparam int FLUSH_ENTRIES = 1024;

  typedef enum logic [1:0] {
    SGC_IDLE,
    SGC_FLUSH
  } sgc_flush_e;

  typedef struct packed {
    logic        valid;
    logic [47:0] da;
    logic [15:0] len_type;
    logic [11:0] length;
    logic        is_pause;
  } sgc_frame_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] ports;
    logic       multicast;
  } sgc_entry_s;

endpackage

// ==== verilog/sgc_age_timer.sv ====
// Aging period timer: emits one pulse per aging tick.
// Assumes the enable and fast controls are synchronous to core_clk.
module sgc_age_timer
  import sgc_pkg::*;
#(
  parameter longint NORM_CYC = NORM_AGE_CYC,
  parameter int     FAST_CYC = FAST_AGE_CYC
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic age_en,
  input  wire logic fast,
  output logic      age_tick
);

  typedef struct packed {
    logic [39:0] cnt;
    logic        tick;
  } sgc_timer_s;

  sgc_timer_s st;
  sgc_timer_s next_st;
  logic [39:0] limit;

  always_comb begin
    limit = fast ? 40'(FAST_CYC - 1) : 40'(NORM_CYC - 1);
    next_st = st;
    next_st.tick = 1'b0;
    if (!age_en) begin
      next_st.cnt = '0;
    end else if (st.cnt >= limit) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 40'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign age_tick = st.tick;

endmodule

// ==== testbench/sgc_global_ctrl_chk.sv ====
// Checker for the switch global control bank, bound to its top module.
// Assumes the bank's package is compiled before it.
module sgc_global_ctrl_chk
  import sgc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       wb_err_o,
  input wire logic [3:0] link_up,
  input wire logic [3:0] learn_dis,
  input wire logic [3:0] an_tx_pause,
  input wire logic [3:0] an_rx_pause,
  input wire sgc_frame_s frame_in,
  input wire logic       frame_drop,
  input wire sgc_entry_s table_entry,
  input wire logic [9:0] table_index,
  input wire logic       table_clear,
  input wire logic       age_all,
  input wire logic [3:0] tx_flow_en,
  input wire logic [3:0] rx_flow_en,
  input wire logic       flush_busy
);
  // ==========================================================================
  // Helpers
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [10:0] busy_cnt;
  wire         fr_valid = frame_in.valid;
  wire         walk_hit = flush_busy && table_entry.valid && !table_entry.multicast
                          && $countones(table_entry.ports) == 1
                          && |(table_entry.ports & learn_dis);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      busy_cnt <= 11'h0;
    else
      busy_cnt <= flush_busy ? busy_cnt + 11'h1 : 11'h0;
  end
  // ==========================================================================
  // Properties
  flush_span_a:
    assert property ($fell(flush_busy) |-> busy_cnt == 11'h400) else $error("bad flush span");
  index_walk_a:
    assert property (flush_busy && $past(flush_busy) |-> table_index == $past(table_index) + 10'h1)
    else $error("table walk skipped");
  clear_match_a:
    assert property (table_clear == $past(walk_hit)) else $error("bad entry clear");
  pause_drop_a:
    assert property (fr_valid && frame_in.is_pause && frame_in.len_type == PAUSE_ETHERTYPE
      |=> frame_drop) else $error("pause frame kept");
  drop_cause_a:
    assert property (frame_drop |-> $past(fr_valid)) else $error("drop without frame");
  tx_gate_a:
    assert property (tx_flow_en == an_tx_pause || tx_flow_en == 4'h0) else $error("tx flow");
  rx_gate_a:
    assert property (rx_flow_en == an_rx_pause || rx_flow_en == 4'h0) else $error("rx flow");
  loss_age_a:
    assert property (|($past(link_up) & ~link_up) |=> age_all) else $error("no age all");
  age_cause_a:
    assert property (age_all |-> |($past(link_up, 2) & ~$past(link_up)))
    else $error("stray age all");
  cover property ($fell(flush_busy));
  cover property (frame_drop);
  cover property (age_all);
  cover property (wb_err_o);
endmodule

bind sgc_global_ctrl sgc_global_ctrl_chk u_sgc_global_ctrl_chk (
  .core_clk    (core_clk),
  .sys_rst     (sys_rst),
  .wb_err_o    (wb_err_o),
  .link_up     (link_up),
  .learn_dis   (learn_dis),
  .an_tx_pause (an_tx_pause),
  .an_rx_pause (an_rx_pause),
  .frame_in    (frame_in),
  .frame_drop  (frame_drop),
  .table_entry (table_entry),
  .table_index (table_index),
  .table_clear (table_clear),
  .age_all     (age_all),
  .tx_flow_en  (tx_flow_en),
  .rx_flow_en  (rx_flow_en),
  .flush_busy  (flush_busy)
);

// ==== testbench/test_sgc_global_ctrl.sv ====
// Self-checking bench for the switch global control bank.
// Assumes the package, the design and its checker are compiled first.
module test_sgc_global_ctrl;
  import sgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FAST_T = 20;
  localparam int NORM_T = 200;
  // ==========================================================================
  // Signals and design
  logic        core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, err;
  logic        pause_dis_strap, frame_drop, table_clear, age_tick, age_all, flush_busy;
  logic        large_frame_enable, aggressive_backoff;
  logic [3:0]  wb_sel_i, link_up, learn_dis, an_tx_pause, an_rx_pause, tx_flow_en, rx_flow_en;
  logic [7:0]  wb_adr_i;
  logic [9:0]  table_index;
  logic [31:0] wb_dat_i, wb_dat_o, rd, d;
  sgc_frame_s  frame_in, f;
  sgc_entry_s  table_entry;
  int          n_mismatch, cmp_count, seed, i;

  assign table_entry = {~table_index[9], table_index[7:4], table_index[8]};
  sgc_global_ctrl #(
    .NORM_CYC (NORM_T),
    .FAST_CYC (FAST_T)
  ) u_sgc_global_ctrl (
    .core_clk           (core_clk),
    .sys_rst            (sys_rst),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_dat_i           (wb_dat_i),
    .wb_sel_i           (wb_sel_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .wb_err_o           (wb_err_o),
    .pause_dis_strap    (pause_dis_strap),
    .link_up            (link_up),
    .learn_dis          (learn_dis),
    .an_tx_pause        (an_tx_pause),
    .an_rx_pause        (an_rx_pause),
    .frame_in           (frame_in),
    .frame_drop         (frame_drop),
    .table_entry        (table_entry),
    .table_index        (table_index),
    .table_clear        (table_clear),
    .age_tick           (age_tick),
    .age_all            (age_all),
    .large_frame_enable (large_frame_enable),
    .tx_flow_en         (tx_flow_en),
    .rx_flow_en         (rx_flow_en),
    .aggressive_backoff (aggressive_backoff),
    .flush_busy         (flush_busy)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, dat};
    do @(posedge core_clk); while (!(wb_ack_o | wb_err_o));
    rd = wb_dat_o;
    err = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask

  task automatic rst(input logic s);
    pause_dis_strap <= s;
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic ticks(input int n);
    for (i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1;
      if (age_tick === 1'b1)
        break;
    end
  endtask

  function automatic logic drop_of(input sgc_frame_s fr, input logic m, input logic c,
                                   input logic lg);
    return (m ? (fr.len_type == PAUSE_ETHERTYPE || fr.da == PAUSE_DA) : fr.is_pause)
      | (c && fr.len_type < LEN_LIMIT && fr.len_type != {4'h0, fr.length})
      | (fr.length > (lg ? LARGE_FRAME_MAX : STD_FRAME_MAX));
  endfunction

  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    results();
  end
  // ==========================================================================
  // Sequence
  initial begin
    seed = 30133;
    {n_mismatch, cmp_count} = '0;
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {44'h0, 4'h1};
    {link_up, learn_dis, an_tx_pause, an_rx_pause} = 16'hf5a6;
    frame_in = '0;
    for (i = 0; i < 2; i++) begin
      rst(i[0]);
      wb(0, REG_GC1_ADDR, 0);
      chk(rd, {24'h0, GC1_RESET | {2'h0, i[0], i[0], 4'h0}});
      chk({tx_flow_en, rx_flow_en}, i[0] ? 8'h0 : 8'ha6);
      wb(0, REG_GC0_ADDR, 0);
      chk(rd, {27'h0, GC0_RESET});
    end
    for (i = 0; i < 12; i++) begin
      d = $random(seed);
      {an_tx_pause, an_rx_pause} <= d[15:8];
      wb(1, REG_GC1_ADDR, d);
      wb(0, REG_GC1_ADDR, 0);
      chk(rd, {25'h0, d[6:0]});
      chk({large_frame_enable, aggressive_backoff}, {d[6], d[0]});
      chk({tx_flow_en, rx_flow_en}, {d[5] ? 4'h0 : d[15:12], d[4] ? 4'h0 : d[11:8]});
    end
    wb(1, REG_GC0_ADDR, 32'hef);
    wb(0, REG_GC0_ADDR, 0);
    chk(rd, 32'h0f);
    wb(1, 8'h40, 32'hff);
    chk(err, 1'b1);
    wb(0, REG_GC0_ADDR, 0);
    chk(rd, 32'h0f);
    for (i = 0; i < 32; i++) begin
      if (i[2:0] == 3'h0) begin
        wb(1, REG_GC0_ADDR, {30'h0, i[3], 1'b0});
        wb(1, REG_GC1_ADDR, {25'h0, i[3], 2'h0, i[4], 3'h4});
      end
      d = $random(seed);
      f.valid = 1'b1;
      f.da = d[0] ? PAUSE_DA : {d, 16'h0};
      f.length = {d[30:29], d[17:8]};
      f.len_type = d[2:1] == 2'h0 ? PAUSE_ETHERTYPE
                 : d[2:1] == 2'h1 ? {4'h0, f.length} : {6'h0, d[27:18]};
      f.is_pause = d[3];
      @(posedge core_clk);
      frame_in <= f;
      @(posedge core_clk);
      frame_in.valid <= 1'b0;
      #1;
      chk(frame_drop, drop_of(f, i[3], i[4], i[3]));
    end
    wb(1, REG_GC0_ADDR, 32'h10);
    wb(0, REG_GC0_ADDR, 0);
    chk(rd[4], 1'b1);
    wb(0, REG_STAT_ADDR, 0);
    chk(rd, {22'h0, 2'h1, link_up, learn_dis});
    wait (flush_busy === 1'b0);
    wb(0, REG_GC0_ADDR, 0);
    chk(rd[4], 1'b0);
    wb(1, REG_GC0_ADDR, 32'h01);
    link_up <= 4'h7;
    @(posedge core_clk);
    #1;
    chk(age_all, 1'b1);
    ticks(40);
    chk(i < FAST_T, 1'b1);
    ticks(NORM_T + 50);
    chk(i, NORM_T - 1);
    wb(1, REG_GC1_ADDR, 0);
    ticks(250);
    chk(i, 250);
    wb(1, REG_GC1_ADDR, 32'h06);
    ticks(40);
    ticks(40);
    chk(i, FAST_T - 1);
    results();
  end
endmodule
